/* File: hdl/fbo_consts.svh */
// timing and field constants for the flash bus host controller
// assumes a 125 MHz clk; counts derive from ns figures
`ifndef FBO_CONSTS_SVH
`define FBO_CONSTS_SVH
`define FBO_CLK_NS 8
`define FBO_ACC_NS 70
`define FBO_WP_NS 35
`define FBO_WSETUP_NS 8
`define FBO_RH_NS 50
`define FBO_RP_NS 500
`define FBO_CYC_UP(ns) ((((ns) + `FBO_CLK_NS - 1) / `FBO_CLK_NS) < 1 ? 1 : \
	(((ns) + `FBO_CLK_NS - 1) / `FBO_CLK_NS))
`define FBO_ACC_CYC `FBO_CYC_UP(`FBO_ACC_NS)
`define FBO_WP_CYC `FBO_CYC_UP(`FBO_WP_NS)
`define FBO_WSETUP_CYC `FBO_CYC_UP(`FBO_WSETUP_NS)
`define FBO_RH_CYC `FBO_CYC_UP(`FBO_RH_NS)
`define FBO_RP_CYC `FBO_CYC_UP(`FBO_RP_NS)
// pins launch one cycle after the state, then four cycles through the synchroniser
`define FBO_RD_PIPE_CYC 5
`define FBO_CNT_W 8
`define FBO_A6_BIT 6
`define FBO_A1_BIT 1
`define FBO_A0_BIT 0
`define FBO_LOCK_A1 1'h1
`define FBO_LOCK_A0 1'h0
`define FBO_LO_BYTE_MSB 7
`define FBO_TOP_BIT 15
`define FBO_MID_LSB 8
`define FBO_MID_MSB 14
`endif

/* File: hdl/fbo_pkg.sv */
// types for the flash bus host controller
// shared by the controller, its checker, the flash model and the bench
package fbo_pkg;
	typedef enum logic [2:0] {
		FBO_OP_READ = 3'h0,
		FBO_OP_WRITE = 3'h1,
		FBO_OP_LOCK = 3'h2,
		FBO_OP_UNLOCK = 3'h3,
		FBO_OP_RESET = 3'h4
	} fbo_op_t;
	typedef struct packed {
		fbo_op_t op;
		logic byte_mode;
		logic [17:0] addr;
		logic [15:0] wdata;
	} fbo_req_t;
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic reset_n;
		logic high_id_voltage;
		logic byte_n;
		logic [16:0] addr;
	} fbo_ctl_t;
	typedef enum logic [2:0] {
		FBO_ST_IDLE = 3'h0,
		FBO_ST_RD = 3'h1,
		FBO_ST_WSET = 3'h2,
		FBO_ST_WPULSE = 3'h3,
		FBO_ST_WHOLD = 3'h4,
		FBO_ST_RST = 3'h5,
		FBO_ST_RREC = 3'h6
	} fbo_state_t;
endpackage

/* File: hdl/fbo_sync.sv */
// three-stage synchroniser for pins from the flash device
// a change is taken once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module fbo_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	always_ff @(posedge clk) begin
		if (reset) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (reset) begin
					dout[i] <= 1'b0;
				end else if (s2_reg[i] == s3_reg[i]) begin
					dout[i] <= s3_reg[i];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

/* File: hdl/fbo_host.sv */
// host-side controller driving a parallel boot-sector flash by its pins
// assumes the testbench resolves dq and the top data/address pin from enables
// Summary of operation
// - reads drive chip select and output gate low, write strobe high
// - command writes drive write strobe and chip select low, output gate high
// - sector lock: strobe low, id voltage on reset, A6 selects lock or unlock
`timescale 1ns/10ps
`default_nettype none
`include "fbo_consts.svh"
module fbo_host import fbo_pkg::*; #(
	parameter int CNT_W = `FBO_CNT_W
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic req_valid,
	input wire fbo_req_t req,
	output logic req_ready,
	output logic [15:0] rsp_data,
	output logic rsp_valid,
	output logic dev_ready,
	output fbo_ctl_t ctl,
	output logic [14:0] dq_out,
	output logic [14:0] dq_oe,
	input wire logic [14:0] dq_in,
	output logic top_data_or_low_addr_out,
	output logic top_data_or_low_addr_oe,
	input wire logic top_data_or_low_addr_in,
	input wire logic ready_busy_n
);
	////////////////////////////////////////////////////////////////////////
	fbo_state_t state_reg;
	fbo_req_t cur_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [15:0] rd_sync;
	logic rb_sync;

	// all device pins are asynchronous to clk
	fbo_sync #(.WIDTH(17)) u_sync (
		.clk(clk),
		.reset(reset),
		.din({ready_busy_n, top_data_or_low_addr_in, dq_in}),
		.dout({rb_sync, rd_sync})
	);

	function automatic logic [15:0] pick_read(input logic byte_mode, input logic [15:0] d);
		// device already routes the chosen byte onto the low lane
		pick_read = byte_mode ? {8'h00, d[`FBO_LO_BYTE_MSB:0]} : d;
	endfunction

	// counts are one-based: the last cycle of a phase sees a value of one
	function automatic logic [CNT_W-1:0] cyc(input int n);
		cyc = CNT_W'(n);
	endfunction

	// write phases share one decode: select, data drive and id voltage follow it
	function automatic logic in_write(input fbo_state_t s);
		in_write = s inside {FBO_ST_WSET, FBO_ST_WPULSE, FBO_ST_WHOLD};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// sequencer
	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= FBO_ST_RST;
			cnt_reg <= cyc(`FBO_RP_CYC);
			cur_reg <= '0;
		end else begin
			unique case (state_reg)
				FBO_ST_IDLE: begin
					// requests outside idle are dropped, not queued
					if (req_valid) begin
						cur_reg <= req;
						unique case (req.op)
							FBO_OP_READ: begin
								state_reg <= FBO_ST_RD;
								// full access time covers leaving standby
								// data is taken only once the synchroniser has settled
								cnt_reg <= cyc(`FBO_ACC_CYC + `FBO_RD_PIPE_CYC);
							end
							FBO_OP_RESET: begin
								state_reg <= FBO_ST_RST;
								cnt_reg <= cyc(`FBO_RP_CYC);
							end
							default: begin
								state_reg <= FBO_ST_WSET;
								cnt_reg <= cyc(`FBO_WSETUP_CYC);
							end
						endcase
					end
				end
				FBO_ST_RD, FBO_ST_WHOLD, FBO_ST_RREC: begin
					if (cnt_reg > cyc(1)) begin
						cnt_reg <= cnt_reg - cyc(1);
					end else begin
						state_reg <= FBO_ST_IDLE;
					end
				end
				FBO_ST_WSET: begin
					if (cnt_reg > cyc(1)) begin
						cnt_reg <= cnt_reg - cyc(1);
					end else begin
						state_reg <= FBO_ST_WPULSE;
						cnt_reg <= cyc(`FBO_WP_CYC);
					end
				end
				FBO_ST_WPULSE: begin
					if (cnt_reg > cyc(1)) begin
						cnt_reg <= cnt_reg - cyc(1);
					end else begin
						// strobe rises here; address and data stay put through hold
						state_reg <= FBO_ST_WHOLD;
						cnt_reg <= cyc(`FBO_WSETUP_CYC);
					end
				end
				FBO_ST_RST: begin
					if (cnt_reg > cyc(1)) begin
						cnt_reg <= cnt_reg - cyc(1);
					end else begin
						state_reg <= FBO_ST_RREC;
						cnt_reg <= cyc(`FBO_RH_CYC);
					end
				end
				// unused code: fall back to a fresh device reset
				default: begin
					state_reg <= FBO_ST_RST;
					cnt_reg <= cyc(`FBO_RP_CYC);
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drive
	always_ff @(posedge clk) begin
		if (reset) begin
			ctl <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b0,
				high_id_voltage: 1'b0, byte_n: 1'b1, addr: '0};
			dq_out <= '0;
			dq_oe <= '0;
			top_data_or_low_addr_out <= 1'b0;
			top_data_or_low_addr_oe <= 1'b0;
		end else begin
			// idle leaves chip select and reset high: device in standby
			ctl.ce_n <= !((state_reg == FBO_ST_RD) || in_write(state_reg));
			ctl.oe_n <= (state_reg != FBO_ST_RD);
			// strobe high outside the pulse keeps reads from turning into writes
			ctl.we_n <= (state_reg != FBO_ST_WPULSE);
			// reset pulse long enough to abort a running program or erase
			ctl.reset_n <= (state_reg != FBO_ST_RST);
			ctl.high_id_voltage <= (cur_reg.op inside {FBO_OP_LOCK, FBO_OP_UNLOCK}) &&
				in_write(state_reg);
			ctl.byte_n <= !cur_reg.byte_mode;
			// word address is the upper 17 bits; byte bit rides on pin 15
			ctl.addr <= cur_reg.addr[17:1];
			if (cur_reg.op == FBO_OP_LOCK || cur_reg.op == FBO_OP_UNLOCK) begin
				ctl.addr[`FBO_A6_BIT] <= (cur_reg.op == FBO_OP_UNLOCK);
				ctl.addr[`FBO_A1_BIT] <= `FBO_LOCK_A1;
				ctl.addr[`FBO_A0_BIT] <= `FBO_LOCK_A0;
			end
			// data driven only in write phases, never while the device may drive
			if (in_write(state_reg)) begin
				dq_out <= cur_reg.wdata[14:0];
				dq_oe[`FBO_LO_BYTE_MSB:0] <= '1;
				dq_oe[`FBO_MID_MSB:`FBO_MID_LSB] <= {7{!cur_reg.byte_mode}};
			end else begin
				dq_oe <= '0;
			end
			if (cur_reg.byte_mode) begin
				// in byte mode pin 15 is an address input, driven always
				top_data_or_low_addr_out <= cur_reg.addr[0];
				top_data_or_low_addr_oe <= 1'b1;
			end else begin
				top_data_or_low_addr_out <= cur_reg.wdata[`FBO_TOP_BIT];
				// word mode: pin floats outside writes so the device can drive it
				top_data_or_low_addr_oe <= in_write(state_reg);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// answers
	always_ff @(posedge clk) begin
		if (reset) begin
			rsp_data <= '0;
			rsp_valid <= 1'b0;
			req_ready <= 1'b0;
			dev_ready <= 1'b0;
		end else begin
			// array, id codes or status alike: host just samples the lanes
			rsp_valid <= (state_reg == FBO_ST_RD) && (cnt_reg == cyc(1));
			if ((state_reg == FBO_ST_RD) && (cnt_reg == cyc(1))) begin
				rsp_data <= pick_read(cur_reg.byte_mode, rd_sync);
			end
			req_ready <= (state_reg == FBO_ST_IDLE) && !req_valid;
			// low while the device programs, erases or recovers from reset
			dev_ready <= rb_sync;
		end
	end
endmodule
`default_nettype wire

/* File: dv/fbo_host_asserts.sv */
// checker for the flash bus host controller pins
// assumes binding onto fbo_host, one clock domain
`timescale 1ns/10ps
`default_nettype none
module fbo_host_asserts import fbo_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic rsp_valid,
	input wire fbo_ctl_t ctl,
	input wire logic [14:0] dq_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_read_levels: assert property (!ctl.oe_n |-> !ctl.ce_n && ctl.we_n)
		else $error("read strobes wrong");
	a_read_no_drive: assert property (!ctl.oe_n |-> dq_oe == 15'h0)
		else $error("host drives during read");
	a_read_answer: assert property ($fell(ctl.oe_n) |-> ##[8:16] rsp_valid)
		else $error("read gave no answer");
	a_write_levels: assert property (!ctl.we_n |-> !ctl.ce_n && ctl.oe_n)
		else $error("write strobes wrong");
	a_write_pulse: assert property ($fell(ctl.we_n) |-> !ctl.we_n [*5] ##1 ctl.we_n)
		else $error("write pulse length wrong");
	a_lock_addr: assert property (ctl.high_id_voltage && !ctl.we_n |->
		ctl.addr[1] && !ctl.addr[0] && ctl.reset_n)
		else $error("lock address bits wrong");
	c_read: cover property ($fell(ctl.oe_n));
	c_write: cover property ($fell(ctl.we_n) && !ctl.high_id_voltage);
	c_lock: cover property (!ctl.we_n && ctl.high_id_voltage);
endmodule
`default_nettype wire

/* File: dv/fbo_flash_model.sv */
// small behavioural model of the flash device on the host pins
// assumes the bench resolves the data wires from all enables
`timescale 1ns/10ps
`default_nettype none
module fbo_flash_model import fbo_pkg::*; (
	input wire logic clk,
	input wire fbo_ctl_t ctl,
	input wire logic [15:0] dq,
	output logic [15:0] dq_drv,
	output logic [15:0] dq_en,
	output logic ready_busy_n
);
	logic [15:0] mem [0:255];
	logic [15:0] rd;
	logic [7:0] busy = 8'h0;
	logic [3:0] acc = 4'h0;
	logic locked = 1'h0;
	logic we_q = 1'h1;
	logic sel;
	assign sel = !ctl.ce_n && ctl.reset_n && !ctl.high_id_voltage;
	assign rd = busy != 8'h0 ? 16'h0 : mem[ctl.addr[7:0]];
	assign ready_busy_n = busy == 8'h0;
	assign dq_en = (sel && !ctl.oe_n) ? (ctl.byte_n ? 16'hffff : 16'h00ff) : 16'h0;
	// garbage until the access time has run, so early sampling shows up
	assign dq_drv = acc < 4'h8 ? ~rd : ctl.byte_n ? rd :
		{8'h0, dq[15] ? rd[15:8] : rd[7:0]};
	always @(posedge clk) begin
		acc <= (sel && acc != 4'hf) ? acc + 4'h1 : 4'h0;
		we_q <= ctl.we_n;
		if (ctl.we_n && !we_q && !ctl.ce_n && ctl.reset_n) begin
			if (ctl.high_id_voltage)
				locked <= !ctl.addr[6];
			else begin
				busy <= 8'h14;
				if (ctl.byte_n)
					mem[ctl.addr[7:0]] <= dq;
				else if (dq[15])
					mem[ctl.addr[7:0]][15:8] <= dq[7:0];
				else
					mem[ctl.addr[7:0]][7:0] <= dq[7:0];
			end
		end else if (busy != 8'h0 && ctl.reset_n)
			busy <= busy - 8'h1;
	end
endmodule
`default_nettype wire

/* File: dv/flash_bus_operation_decode_test.sv */
// self-checking bench for the flash bus host controller
// assumes fbo_host, the flash model and the checker are compiled first
`timescale 1ns/10ps
`default_nettype none
bind fbo_host fbo_host_asserts i_fbo_host_asserts (.clk(clk), .reset(reset),
	.rsp_valid(rsp_valid), .ctl(ctl), .dq_oe(dq_oe));
module flash_bus_operation_decode_test import fbo_pkg::*;;
	logic clk = 1'h0, reset = 1'h1, req_valid = 1'h0, req_ready, rsp_valid, dev_ready;
	logic t_out, t_oe, rbn;
	logic [15:0] rsp_data, f_d, f_e, dq;
	logic [15:0] flt = 16'h5a5a;
	logic [14:0] dq_out, dq_oe;
	fbo_req_t req = '0;
	fbo_ctl_t ctl;
	int n_fail = 0, num_checks = 0, cyc = 0;
	always #4 clk = ~clk;
	always @(posedge clk) flt <= ~flt;
	// undriven wires flip every cycle rather than keep a stale value
	assign dq = (f_d & f_e) | ({t_out, dq_out} & {t_oe, dq_oe}) | (flt & ~f_e & ~{t_oe, dq_oe});
	fbo_host i_fbo_host (.clk(clk), .reset(reset), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
		.dev_ready(dev_ready), .ctl(ctl), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq[14:0]),
		.top_data_or_low_addr_out(t_out), .top_data_or_low_addr_oe(t_oe),
		.top_data_or_low_addr_in(dq[15]), .ready_busy_n(rbn));
	fbo_flash_model i_fbo_flash_model (.clk(clk), .ctl(ctl), .dq(dq), .dq_drv(f_d),
		.dq_en(f_e), .ready_busy_n(rbn));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask
	task test_done;
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			test_done;
		end
	end
	task op(input fbo_op_t o, input logic bm, input logic [17:0] a, input logic [15:0] w);
		int i;
		i = 0;
		// let the last request's edge settle before trusting the ready hint
		@(negedge clk);
		while (req_ready !== 1'h1 && i < 300) begin
			@(negedge clk);
			i++;
		end
		@(posedge clk);
		req_valid <= 1'h1;
		req <= '{o, bm, a, w};
		@(posedge clk);
		req_valid <= 1'h0;
	endtask
	task rd(input logic bm, input logic [17:0] a, input logic [15:0] e);
		int i;
		op(FBO_OP_READ, bm, a, 16'h0);
		i = 0;
		while (rsp_valid !== 1'h1 && i < 40) begin
			@(negedge clk);
			i++;
		end
		chk("read answer", {15'h0, rsp_valid}, 16'h1);
		chk("read data", rsp_data, e);
	endtask
	task t_boot;
		rd(1'h0, 18'h6, 16'hbeef);
	endtask
	task t_word;
		op(FBO_OP_WRITE, 1'h0, 18'h10, 16'ha5c3);
		repeat (14) @(negedge clk);
		chk("busy", {15'h0, dev_ready}, 16'h0);
		repeat (30) @(negedge clk);
		chk("ready", {15'h0, dev_ready}, 16'h1);
		rd(1'h0, 18'h10, 16'ha5c3);
	endtask
	task t_byte;
		rd(1'h1, 18'h11, 16'h00a5);
		rd(1'h1, 18'h10, 16'h00c3);
	endtask
	task t_lock;
		op(FBO_OP_LOCK, 1'h0, 18'h0, 16'h0);
		repeat (12) @(negedge clk);
		chk("locked", {15'h0, i_fbo_flash_model.locked}, 16'h1);
		op(FBO_OP_UNLOCK, 1'h0, 18'h0, 16'h0);
		repeat (12) @(negedge clk);
		chk("unlocked", {15'h0, i_fbo_flash_model.locked}, 16'h0);
	endtask
	task t_rst;
		op(FBO_OP_RESET, 1'h0, 18'h0, 16'h0);
		rd(1'h0, 18'h6, 16'hbeef);
	endtask
	initial begin
		i_fbo_flash_model.mem[3] = 16'hbeef;
		repeat (4) @(posedge clk);
		reset <= 1'h0;
		t_boot;
		t_word;
		t_byte;
		t_lock;
		t_rst;
		test_done;
	end
endmodule
`default_nettype wire
